// ==== rtl/twtp_top.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "twtp_regs.svh"
module twtp_top #(
    parameter logic [31:0] ENTRY_SIG = 32'h5a3c_96e1, // arbitrary value
    parameter logic [31:0] ID_CODE   = 32'h1234_5679, // arbitrary value
    parameter int          CHAIN_LEN = `TWTP_CHAIN_LEN
) (
    // core clock and reset
    input  wire logic                 core_clk_i,
    input  wire logic                 arst_n_i,
    // serial link
    input  wire logic                 serial_test_clock_i,
    input  wire logic                 serial_test_data_i,
    output logic                      serial_test_data_o,
    output logic                      serial_test_data_oe_o,
    input  wire logic                 test_clear_n_i,
    output logic                      test_clear_pullup_o,
    // chip status inputs
    input  wire logic                 boot_ready_i,
    input  wire logic                 config_ready_i,
    input  wire logic                 sleeping_i,
    // chip control outputs
    output logic                      force_device_reset_o,
    output logic                      boot_hold_o,
    output logic                      two_wire_test_mode_o,
    output logic                      debug_tap_enable_o,
    output logic                      debug_tck_o,
    output logic                      debug_tms_o,
    output logic                      debug_tdi_o,
    input  wire logic                 debug_tdo_i,
    // xnor chain
    input  wire logic [CHAIN_LEN-1:0] chain_pins_i,
    output logic                      xnor_mode_o,
    output logic                      xnor_out_o
);
    initial begin
        if (CHAIN_LEN < 2)
        begin
            $error("chain too short");
        end
    end

    // =====================================================
    // core reset release and link status sync
    logic [1:0] rst_sync_q;
    logic       rst_n;
    logic [1:0] boot_ready_q, cfg_q, slp_q, dtdo_q;
    always_ff @(posedge core_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i) rst_sync_q <= 2'h0;
        else rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
    assign rst_n = rst_sync_q[1];
    assign test_clear_pullup_o = 1'b1;

    // =====================================================
    // link domain: clear pin as test reset
    logic clr_n;
    assign clr_n = test_clear_n_i & rst_n;

    always_ff @(posedge serial_test_clock_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            boot_ready_q <= 2'h0;
            cfg_q  <= 2'h0;
            slp_q  <= 2'h0;
            dtdo_q <= 2'h0;
        end
        else
        begin
            boot_ready_q <= {boot_ready_q[0], boot_ready_i};
            cfg_q  <= {cfg_q[0], config_ready_i};
            slp_q  <= {slp_q[0], sleeping_i};
            dtdo_q <= {dtdo_q[0], debug_tdo_i};
        end
    end

    // =====================================================
    // entry signature capture while clear is low
    logic [31:0] sig_q;
    logic [31:0] sig_word;
    logic [5:0]  sig_cnt_q;
    logic        sig_rst;
    logic        mode_q;
    // clear high restarts capture even with the link clock stopped
    assign sig_rst  = test_clear_n_i | ~rst_n;
    assign sig_word = {sig_q[30:0], serial_test_data_i};

    always_ff @(posedge serial_test_clock_i or posedge sig_rst)
    begin
        if (sig_rst)
        begin
            sig_q     <= 32'h0;
            sig_cnt_q <= 6'h0;
        end
        else if (sig_cnt_q < 6'(`TWTP_SIG_BITS))
        begin
            sig_q     <= sig_word;
            sig_cnt_q <= sig_cnt_q + 6'h1;
        end
    end

    // decided on the 32nd edge, while clear is still low
    always_ff @(posedge serial_test_clock_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mode_q <= 1'b0;
        end
        else if (!test_clear_n_i && sig_cnt_q == 6'(`TWTP_SIG_BITS - 1))
        begin
            mode_q <= (sig_word == ENTRY_SIG);
        end
    end
    assign two_wire_test_mode_o = mode_q;

    // =====================================================
    // four phase converter: tms, tdi, tdo slot, tck
    logic [1:0] ph_q;
    logic       tms_q, tdi_q, tck_en;
    always_ff @(posedge serial_test_clock_i or negedge clr_n)
    begin
        if (!clr_n)
        begin
            ph_q  <= 2'h0;
            tms_q <= 1'b1;
            tdi_q <= 1'b0;
        end
        else if (mode_q)
        begin
            ph_q <= ph_q + 2'h1;
            if (ph_q == 2'h0) tms_q <= serial_test_data_i;
            if (ph_q == 2'h1) tdi_q <= serial_test_data_i;
        end
    end
    assign tck_en = mode_q && (ph_q == 2'(`TWTP_PHASES - 1));

    // =====================================================
    // master tap state machine
    twtp_pkg::twtp_tap_state_t st_q, st_d;
    always_comb
    begin
        st_d = st_q;
        case (st_q)
            twtp_pkg::TS_RESET:   st_d = tms_q ? twtp_pkg::TS_RESET
                                               : twtp_pkg::TS_IDLE;
            twtp_pkg::TS_IDLE:    st_d = tms_q ? twtp_pkg::TS_SEL_DR
                                               : twtp_pkg::TS_IDLE;
            twtp_pkg::TS_SEL_DR:  st_d = tms_q ? twtp_pkg::TS_SEL_IR
                                               : twtp_pkg::TS_CAP_DR;
            twtp_pkg::TS_CAP_DR,
            twtp_pkg::TS_SH_DR:   st_d = tms_q ? twtp_pkg::TS_EX1_DR
                                               : twtp_pkg::TS_SH_DR;
            twtp_pkg::TS_EX1_DR:  st_d = tms_q ? twtp_pkg::TS_UPD_DR
                                               : twtp_pkg::TS_PAU_DR;
            twtp_pkg::TS_PAU_DR:  st_d = tms_q ? twtp_pkg::TS_EX2_DR
                                               : twtp_pkg::TS_PAU_DR;
            twtp_pkg::TS_EX2_DR:  st_d = tms_q ? twtp_pkg::TS_UPD_DR
                                               : twtp_pkg::TS_SH_DR;
            twtp_pkg::TS_UPD_DR,
            twtp_pkg::TS_UPD_IR:  st_d = tms_q ? twtp_pkg::TS_SEL_DR
                                               : twtp_pkg::TS_IDLE;
            twtp_pkg::TS_SEL_IR:  st_d = tms_q ? twtp_pkg::TS_RESET
                                               : twtp_pkg::TS_CAP_IR;
            twtp_pkg::TS_CAP_IR,
            twtp_pkg::TS_SH_IR:   st_d = tms_q ? twtp_pkg::TS_EX1_IR
                                               : twtp_pkg::TS_SH_IR;
            twtp_pkg::TS_EX1_IR:  st_d = tms_q ? twtp_pkg::TS_UPD_IR
                                               : twtp_pkg::TS_PAU_IR;
            twtp_pkg::TS_PAU_IR:  st_d = tms_q ? twtp_pkg::TS_EX2_IR
                                               : twtp_pkg::TS_PAU_IR;
            twtp_pkg::TS_EX2_IR:  st_d = tms_q ? twtp_pkg::TS_UPD_IR
                                               : twtp_pkg::TS_SH_IR;
            default:              st_d = twtp_pkg::TS_RESET;
        endcase
    end

    // =====================================================
    // instruction decode helpers
    function automatic logic is_vcmd(input logic [4:0] code);
        return code == `TWTP_IR_VCMD;
    endfunction : is_vcmd

    // reserved codes 0x02 and 0x06 fall back to the bypass cell
    function automatic logic is_bypass(input logic [4:0] code);
        return code != `TWTP_IR_IDCODE && !is_vcmd(code);
    endfunction : is_bypass

    // =====================================================
    // instruction and data registers
    logic [4:0]  ir_sh_q, ir_q;
    logic        byp_q, tdo_q;
    logic [31:0] dr_q;
    logic [7:0]  vcmd_q;
    logic        hold_q, frc_q, sel_q, xnor_q, dr_load_q;
    logic [7:0]  status;
    logic        tap_tdo;

    assign status = {hold_q, boot_ready_q[1], 2'h0, cfg_q[1], 1'b0,
                     slp_q[1], frc_q};

    always_ff @(posedge serial_test_clock_i or negedge clr_n)
    begin
        if (!clr_n)
        begin
            st_q    <= twtp_pkg::TS_RESET;
            ir_sh_q <= 5'h0;
            ir_q    <= `TWTP_IR_IDCODE;
            dr_q    <= 32'h0;
            vcmd_q  <= `TWTP_VCMD_RESET;
            sel_q   <= 1'b1;
        end
        else if (tck_en)
        begin
            st_q <= st_d;
            if (st_q == twtp_pkg::TS_RESET)
            begin
                ir_q  <= `TWTP_IR_IDCODE;
            end
            if (st_q == twtp_pkg::TS_CAP_IR)
                ir_sh_q <= 5'h01;
            if (st_q == twtp_pkg::TS_SH_IR)
                ir_sh_q <= {tdi_q, ir_sh_q[4:1]};
            if (st_q == twtp_pkg::TS_UPD_IR)
            begin
                ir_q <= ir_sh_q;
                if (ir_sh_q == `TWTP_IR_SEL) sel_q <= 1'b1;
                if (ir_sh_q == `TWTP_IR_REL) sel_q <= 1'b0;
            end
            if (st_q == twtp_pkg::TS_CAP_DR)
            begin
                if (ir_q == `TWTP_IR_IDCODE)
                    dr_q <= {ID_CODE[31:1], 1'b1};
                else if (is_vcmd(ir_q))
                    dr_q <= {24'h0, (vcmd_q == `TWTP_SC_STATUS) ?
                             status : vcmd_q};
            end
            if (st_q == twtp_pkg::TS_SH_DR)
            begin
                if (ir_q == `TWTP_IR_IDCODE)
                    dr_q <= {tdi_q, dr_q[31:1]};
                else if (is_vcmd(ir_q))
                    dr_q <= {24'h0, tdi_q, dr_q[7:1]};
            end
            if (st_q == twtp_pkg::TS_UPD_DR && is_vcmd(ir_q))
                vcmd_q <= dr_q[7:0];
        end
    end

    // sub-command strobe, one link clock after update
    always_ff @(posedge serial_test_clock_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            dr_load_q <= 1'b0;
        end
        else
        begin
            dr_load_q <= tck_en && st_q == twtp_pkg::TS_UPD_DR
                         && is_vcmd(ir_q) && sel_q;
        end
    end

    // boot hold flag; survives test reset
    always_ff @(posedge serial_test_clock_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            hold_q <= 1'b0;
        end
        else if (dr_load_q && boot_ready_q[1])
        begin
            if (vcmd_q == `TWTP_SC_SETHOLD) hold_q <= 1'b1;
            if (vcmd_q == `TWTP_SC_CLRHOLD) hold_q <= 1'b0;
        end
    end

    // forced device reset; test logic keeps running
    always_ff @(posedge serial_test_clock_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            frc_q <= 1'b0;
        end
        else if (dr_load_q)
        begin
            if (vcmd_q == `TWTP_SC_FRCRST) frc_q <= 1'b1;
            if (vcmd_q == `TWTP_SC_RELRST) frc_q <= 1'b0;
        end
    end

    // chain mode, left only by power-on reset
    always_ff @(posedge serial_test_clock_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            xnor_q <= 1'b0;
        end
        else if (dr_load_q && vcmd_q == 8'h01)
        begin
            xnor_q <= 1'b1;
        end
    end

    // single bypass cell, zero on capture
    always_ff @(posedge serial_test_clock_i or negedge clr_n)
    begin
        if (!clr_n)
        begin
            byp_q <= 1'b0;
        end
        else if (tck_en && is_bypass(ir_q))
        begin
            if (st_q == twtp_pkg::TS_CAP_DR) byp_q <= 1'b0;
            if (st_q == twtp_pkg::TS_SH_DR) byp_q <= tdi_q;
        end
    end

    // pin data from a flop, settled before the read slot
    always_ff @(posedge serial_test_clock_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tdo_q <= 1'b0;
        end
        else
        begin
            tdo_q <= sel_q ? tap_tdo : dtdo_q[1];
        end
    end

    // =====================================================
    // outputs and gating toward the debug tap
    assign tap_tdo = is_bypass(ir_q) ? byp_q : dr_q[0];
    assign debug_tap_enable_o   = mode_q & ~sel_q;
    assign debug_tck_o          = tck_en & ~sel_q;
    assign debug_tms_o          = tms_q;
    assign debug_tdi_o          = tdi_q & ~sel_q;
    assign serial_test_data_o   = tdo_q;
    assign serial_test_data_oe_o = mode_q && ph_q == 2'h2;
    assign force_device_reset_o = frc_q;
    assign boot_hold_o          = hold_q;

    // =====================================================
    // xnor chain
    assign xnor_mode_o = xnor_q;
    assign xnor_out_o  = (^chain_pins_i) ^ 1'(CHAIN_LEN % 2);
endmodule : twtp_top
`default_nettype wire

// ==== common/twtp_regs.svh ====
`ifndef TWTP_REGS_SVH
`define TWTP_REGS_SVH
`define TWTP_IR_IDCODE   5'h01
`define TWTP_IR_SAMPLE   5'h02
`define TWTP_IR_SEL      5'h04
`define TWTP_IR_REL      5'h05
`define TWTP_IR_EXTEST   5'h06
`define TWTP_IR_VCMD     5'h07
`define TWTP_IR_BYPASS   5'h1f
`define TWTP_VCMD_OFFSET 8'h01
`define TWTP_VCMD_RESET  8'h00
`define TWTP_SC_STATUS   8'h00
`define TWTP_SC_SETHOLD  8'h09
`define TWTP_SC_CLRHOLD  8'h0a
`define TWTP_SC_RELRST   8'hd0
`define TWTP_SC_FRCRST   8'hd1
`define TWTP_ST_HOLD     7
`define TWTP_ST_BOOT_READY     6
`define TWTP_ST_CONFIG_READY   3
`define TWTP_ST_SLEEP    1
`define TWTP_ST_DEVICE_RESET_STATUS   0
`define TWTP_SIG_BITS    32
`define TWTP_PHASES      4
`define TWTP_CHAIN_LEN   107
`define TWTP_XNOR_ADDR   8'h88
`endif

// ==== common/twtp_pkg.sv ====
package twtp_pkg;
    typedef enum logic [3:0] {
        TS_RESET, TS_IDLE, TS_SEL_DR, TS_CAP_DR, TS_SH_DR, TS_EX1_DR,
        TS_PAU_DR, TS_EX2_DR, TS_UPD_DR, TS_SEL_IR, TS_CAP_IR,
        TS_SH_IR, TS_EX1_IR, TS_PAU_IR, TS_EX2_IR, TS_UPD_IR
    } twtp_tap_state_t;
endpackage : twtp_pkg

// ==== verification/twtp_assertions.sv ====
`timescale 1ns/10ps
`default_nettype none
// ====================================================
// port checker
module twtp_checker #(
    parameter int CHAIN_LEN = 107
) (
    // clocks and reset
    input wire logic                 core_clk_i,
    input wire logic                 arst_n_i,
    input wire logic                 serial_test_clock_i,
    // watched ports
    input wire logic                 serial_test_data_oe_o,
    input wire logic                 test_clear_n_i,
    input wire logic                 test_clear_pullup_o,
    input wire logic                 boot_ready_i,
    input wire logic                 force_device_reset_o,
    input wire logic                 boot_hold_o,
    input wire logic                 two_wire_test_mode_o,
    input wire logic [CHAIN_LEN-1:0] chain_pins_i,
    input wire logic                 xnor_mode_o,
    input wire logic                 xnor_out_o
);
    a_pullup_held: assert property (
        @(posedge core_clk_i) disable iff (!arst_n_i) test_clear_pullup_o)
        else $error("clear pull-up request low");
    a_xnor_parity: assert property (
        @(posedge core_clk_i) disable iff (!arst_n_i)
        xnor_mode_o |->
        xnor_out_o == 1'((CHAIN_LEN + $countones(chain_pins_i)) % 2))
        else $error("chain output wrong");
    a_xnor_sticky: assert property (
        @(posedge core_clk_i) disable iff (!arst_n_i)
        xnor_mode_o |=> xnor_mode_o) else $error("chain mode left");
    a_oe_in_clear: assert property (
        @(posedge core_clk_i) disable iff (!arst_n_i)
        !test_clear_n_i |-> !serial_test_data_oe_o)
        else $error("data driven in test reset");
    a_oe_outside: assert property (
        @(posedge core_clk_i) disable iff (!arst_n_i)
        !two_wire_test_mode_o |-> !serial_test_data_oe_o)
        else $error("data driven outside mode");
    a_hold_ready: assert property (
        @(posedge core_clk_i) disable iff (!arst_n_i)
        $changed(boot_hold_o) |-> boot_ready_i)
        else $error("hold changed without boot ready");
    a_force_mode: assert property (
        @(posedge core_clk_i) disable iff (!arst_n_i)
        $changed(force_device_reset_o) |-> two_wire_test_mode_o)
        else $error("device reset changed outside mode");
    a_mode_entry: assert property (
        @(posedge serial_test_clock_i) disable iff (!arst_n_i)
        $rose(two_wire_test_mode_o) |-> !$past(test_clear_n_i))
        else $error("mode entered with clear high");
    a_oe_one_slot: assert property (
        @(posedge serial_test_clock_i) disable iff (!arst_n_i)
        $rose(serial_test_data_oe_o) |=> !serial_test_data_oe_o)
        else $error("data driven beyond one slot");
endmodule : twtp_checker
bind twtp_top twtp_checker #(.CHAIN_LEN(CHAIN_LEN)) u_chk (
    .core_clk_i, .arst_n_i, .serial_test_clock_i, .serial_test_data_oe_o,
    .test_clear_n_i, .test_clear_pullup_o, .boot_ready_i,
    .force_device_reset_o, .boot_hold_o, .two_wire_test_mode_o,
    .chain_pins_i, .xnor_mode_o, .xnor_out_o);
`default_nettype wire

// ==== verification/twtp_probe.sv ====
`timescale 1ns/10ps
`default_nettype none
// ====================================================
// probe model
module twtp_probe (
    // link toward device
    output logic      sclk_o,
    output logic      clr_n_o,
    output wire logic line_o,
    // device data pin
    input  wire logic dev_d_i,
    input  wire logic dev_oe_i
);
    logic d_q = 1'b0;
    logic drv_q = 1'b1;
    logic tdo_q;
    initial sclk_o = 1'b0;
    initial clr_n_o = 1'b1;
    // released line shows inverse of last value
    assign line_o = dev_oe_i ? dev_d_i : (drv_q ? d_q : ~d_q);
    task automatic pulse(input logic d, input logic drv);
        if (drv) d_q = d;
        drv_q = drv;
        #7.5 if (dev_oe_i) tdo_q = dev_d_i;
        #7.5 sclk_o = 1'b1;
        #7.5 if (dev_oe_i) tdo_q = dev_d_i;
        #7.5 sclk_o = 1'b0;
    endtask : pulse
    // tms, tdi, released slot, tck
    task automatic jbit(input logic tms, input logic tdi, output logic tdo);
        pulse(tms, 1'b1);
        pulse(tdi, 1'b1);
        tdo_q = 1'bx;
        pulse(1'b0, 1'b0);
        tdo = tdo_q;
        pulse(tdi, 1'b1);
    endtask : jbit
    task automatic scan(input logic ir, input logic [7:0] v, input int n,
                        output logic [7:0] r);
        logic t;
        r = 8'h00;
        jbit(1'b0, 1'b0, t);
        jbit(1'b1, 1'b0, t);
        if (ir) jbit(1'b1, 1'b0, t);
        jbit(1'b0, 1'b0, t);
        jbit(1'b0, 1'b0, t);
        for (int i = 0; i < n; i++) jbit(i == n - 1, v[i], r[i]);
        jbit(1'b1, 1'b0, t);
        jbit(1'b0, 1'b0, t);
        jbit(1'b0, 1'b0, t); // idle slot carries the sub-command strobe
        #100;
    endtask : scan
    task automatic enter(input logic [31:0] sig);
        clr_n_o = 1'b1;
        d_q = 1'b0;
        drv_q = 1'b1;
        #30 clr_n_o = 1'b0;
        #30;
        for (int i = 31; i >= 0; i--) pulse(sig[i], 1'b1);
        #30 clr_n_o = 1'b1;
        #100;
    endtask : enter
endmodule : twtp_probe
`default_nettype wire

// ==== verification/twtp_top_tb.sv ====
`timescale 1ns/10ps
`default_nettype none
// ====================================================
// two-wire port bench
module twtp_top_tb;
    localparam logic [31:0] SIG = 32'hc3a5_0f96; // arbitrary value
    localparam logic [31:0] IDC = 32'h0f0f_5a7e; // arbitrary value
    logic         clk = 1'b0;
    logic         arst_n = 1'b0;
    logic         boot_ready = 1'b0;
    logic         cfg = 1'b0;
    logic         slp = 1'b0;
    logic [106:0] pins = '0;
    logic [7:0]   r;
    logic         e;
    logic [4:0]   byc [3] = '{5'h1f, 5'h02, 5'h06};
    int           ix [3] = '{0, 53, 106};
    int           err_count = 0;
    int           n_compared = 0;
    wire logic    sclk, clr_n, line, dout, doe, pull, frc, hold, mode;
    wire logic    dbg, tck, tms, tdi, xmode, xout;
    always #10 clk = ~clk;
    twtp_top #(.ENTRY_SIG(SIG), .ID_CODE(IDC)) DUT (
        .core_clk_i(clk), .arst_n_i(arst_n), .serial_test_clock_i(sclk),
        .serial_test_data_i(line), .serial_test_data_o(dout),
        .serial_test_data_oe_o(doe), .test_clear_n_i(clr_n),
        .test_clear_pullup_o(pull), .boot_ready_i(boot_ready),
        .config_ready_i(cfg), .sleeping_i(slp), .force_device_reset_o(frc),
        .boot_hold_o(hold), .two_wire_test_mode_o(mode),
        .debug_tap_enable_o(dbg), .debug_tck_o(tck), .debug_tms_o(tms),
        .debug_tdi_o(tdi), .debug_tdo_i(tdi), .chain_pins_i(pins),
        .xnor_mode_o(xmode), .xnor_out_o(xout));
    twtp_probe u_probe (.sclk_o(sclk), .clr_n_o(clr_n), .line_o(line),
        .dev_d_i(dout), .dev_oe_i(doe));
    task automatic check(input string what, input logic [7:0] got,
                         input logic [7:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            $display("mismatch %s expected %h seen %h", what, exp, got);
            err_count++;
        end
    endtask : check
    task automatic end_of_test();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : end_of_test
    task automatic ir(input logic [4:0] c);
        logic [7:0] t;
        u_probe.scan(1'b1, {3'h0, c}, 5, t);
    endtask : ir
    task automatic dr(input logic [7:0] v);
        u_probe.scan(1'b0, v, 8, r);
    endtask : dr
    initial
    begin
        #400us;
        err_count++;
        end_of_test();
    end
    initial
    begin
        u_probe.pulse(1'b0, 1'b1);
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge clk);
        check("pullup", 8'(pull), 8'h01);
        check("dbg_en", 8'(dbg), 8'h00);
        check("flags", {4'h0, frc, hold, xmode, doe}, 8'h00);
        u_probe.enter(~SIG);
        check("bad_sig", 8'(mode), 8'h00);
        u_probe.enter(SIG);
        check("entry", 8'(mode), 8'h01);
        ir(5'h04);
        check("sel_gate", 8'(dbg), 8'h00);
        ir(5'h01);
        dr(8'h00);
        check("idcode", r, {IDC[7:1], 1'b1});
        foreach (byc[k])
        begin
            ir(byc[k]);
            dr(8'h96);
            check("bypass", r, 8'h2c);
        end
        ir(5'h07);
        dr(8'h09);
        check("hold_refused", 8'(hold), 8'h00);
        @(posedge clk);
        {boot_ready, cfg, slp} <= 3'b111;
        r = 8'h00;
        for (int i = 0; i < 8 && r[6] !== 1'b1; i++) dr(8'h00);
        dr(8'h00);
        check("status", r, 8'h4a);
        dr(8'h09);
        check("hold_set", 8'(hold), 8'h01);
        dr(8'hd1);
        dr(8'h00);
        check("force_rst", 8'(frc), 8'h01);
        dr(8'h00);
        check("status_rst", r, 8'hcb);
        dr(8'h0a);
        dr(8'hd0);
        dr(8'h00);
        dr(8'h00);
        check("status_clr", r, 8'h4a);
        ir(5'h05);
        check("release", 8'(dbg), 8'h01);
        check("dbg_pins", {5'h0, tck, tms, tdi}, 8'h00);
        u_probe.enter(SIG);
        check("test_rst", 8'(dbg), 8'h00);
        u_probe.enter(SIG);
        ir(5'h04);
        ir(5'h07);
        dr(8'h01);
        check("xnor_mode", 8'(xmode), 8'h01);
        e = 1'b1;
        check("xnor_init", 8'(xout), 8'(e));
        foreach (ix[k])
        begin
            @(posedge clk);
            pins[ix[k]] <= ~pins[ix[k]];
            e = ~e;
            repeat (2) @(posedge clk);
            check("xnor_toggle", 8'(xout), 8'(e));
        end
        u_probe.enter(32'h0000_0000);
        check("xnor_kept", 8'(xmode), 8'h01);
        end_of_test();
    end
endmodule : twtp_top_tb
`default_nettype wire
